/* File: clock_source_model.sv */
module clock_source_model (
  // Clock and reset
  input  logic clk,
  input  logic rst_n,
  // Bench control
  input  logic tickEn,
  input  logic wakeKick,
  // To device
  output logic watchdogOscTick,
  output logic pinChange
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] divReg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divReg <= 2'h0;
      watchdogOscTick <= 1'b0;
      pinChange <= 1'b0;
    end else begin
      divReg <= divReg + 2'h1;
      watchdogOscTick <= tickEn && divReg == 2'h3;
      pinChange <= wakeKick;
    end
  end
endmodule

/* File: config_word_checker.sv */
module config_word_checker (
  // Clock and reset
  input logic       clk,
  input logic       rst_n,
  // Pins and state
  input logic       resetPinInput_n,
  input logic       pinChange,
  input logic [2:0] oscMode,
  input logic       internalOscFreq8M,
  input logic       clockOutputEnable,
  input logic       secondaryPinIo,
  input logic       sharedPinIo,
  input logic       codeProtectOn,
  input logic       watchdogEnabled,
  input logic       deviceReset,
  input logic       delayActive,
  input logic       sleeping
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_clock_out_modes: assert property (
    clockOutputEnable == (oscMode == 3'h5 || oscMode == 3'h7)) else $error("clock out");
  chk_pin_io_modes: assert property (
    secondaryPinIo |-> oscMode inside {3'h3, 3'h4, 3'h6}) else $error("pin io");
  chk_crystal_delay: assert property (
    $fell(deviceReset) && oscMode < 3'h3 |-> $past(delayActive)) else $error("no delay");
  chk_delay_in_reset: assert property (
    delayActive |-> deviceReset) else $error("delay out of reset");
  chk_cfg_held: assert property (
    !deviceReset && !$past(deviceReset) |-> $stable({oscMode, internalOscFreq8M,
    codeProtectOn, watchdogEnabled, sharedPinIo})) else $error("config moved");
  chk_wake_pin: assert property (
    sleeping && pinChange |-> ##[1:2] !sleeping) else $error("no wake");
  chk_no_reset: assert property (
    !deviceReset && !watchdogEnabled && (sharedPinIo || resetPinInput_n) |=> !deviceReset)
    else $error("stray reset");
  chk_pin_reset: assert property (
    !sharedPinIo && !resetPinInput_n |-> ##[1:2] deviceReset) else $error("pin ignored");
  cover property ($fell(sleeping));
  cover property ($fell(delayActive));
  cover property (sharedPinIo && !resetPinInput_n);
endmodule

bind config_word_clock_reset_select config_word_checker chk_inst (
  .clk, .rst_n, .resetPinInput_n, .pinChange, .oscMode, .internalOscFreq8M,
  .clockOutputEnable, .secondaryPinIo, .sharedPinIo, .codeProtectOn,
  .watchdogEnabled, .deviceReset, .delayActive, .sleeping);

/* File: config_word_clock_reset_select.v */
`include "config_word_consts.vh"

module config_word_clock_reset_select #(
  parameter [20:0] LONG_DELAY_CYCLES  = `DELAY_LONG_CYCLES,
  parameter [20:0] SHORT_DELAY_CYCLES = `DELAY_SHORT_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Pins and core events
  input  wire        resetPinInput_n,
  input  wire        pinChange,
  input  wire        watchdogOscTick,
  input  wire        sleepRequest,
  input  wire        watchdogClear,
  // Decoded configuration
  output reg  [2:0]  oscMode,
  output reg         internalOscFreq8M,
  output reg         clockOutputEnable,
  output reg         secondaryPinIo,
  output reg         sharedPinIo,
  output reg         codeProtectOn,
  output reg         watchdogEnabled,
  // Device state
  output reg         deviceReset,
  output reg         delayActive,
  output reg         sleeping
);

  // ****************************************
  // States
  // ****************************************
  localparam [3:0] ST_HOLD  = 4'h1;
  localparam [3:0] ST_DELAY = 4'h2;
  localparam [3:0] ST_RUN   = 4'h4;
  localparam [3:0] ST_SLEEP = 4'h8;

  // ****************************************
  // Decoding functions
  // ****************************************
  // Both layouts mapped to one mode code
  function [2:0] decodeMode;
    input        variant14;
    input [11:0] word;
    begin
      if (variant14) begin
        decodeMode = word[2:0];
      end else begin
        case (word[1:0])
          2'h0:    decodeMode = `MODE_XTAL_LOW;
          2'h1:    decodeMode = `MODE_XTAL_STD;
          2'h2:    decodeMode = `MODE_INT_OSC;
          default: decodeMode = `MODE_EXT_RC;
        endcase
      end
    end
  endfunction

  // Field bit at its 8-pin position, one higher on 14-pin
  function fieldBit;
    input        variant14;
    input [11:0] word;
    input [3:0]  pos8;
    begin
      fieldBit = variant14 ? word[pos8 + 4'h1] : word[pos8];
    end
  endfunction

  function isCrystal;
    input [2:0] mode;
    begin
      isCrystal = (mode == `MODE_XTAL_LOW) || (mode == `MODE_XTAL_STD) ||
                  (mode == `MODE_XTAL_FAST);
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg  [11:0] cfgImage_reg;
  reg         variant_reg;
  reg         activeVariant_reg;
  reg  [3:0]  state_reg;
  reg  [3:0]  state_next;
  reg  [20:0] delayCount_reg;
  reg  [20:0] delayCount_next;
  reg         powerUp_reg;
  reg         watchdogReset_reg;
  reg  [7:0]  watchdogCount_reg;

  // ****************************************
  // Bus decode
  // ****************************************
  wire        apbWrite  = psel & penable & pwrite;
  wire        apbSetup  = psel & ~penable;
  wire        hitCfg    = (paddr == `ADDR_CFG);
  wire        hitCtrl   = (paddr == `ADDR_CTRL);
  wire        hitStatus = (paddr == `ADDR_STATUS);
  wire        hitCmd    = (paddr == `ADDR_CMD);
  wire        addrHit   = hitCfg | hitCtrl | hitStatus | hitCmd;

  assign pready  = 1'b1;
  // Unmapped offsets answer with an error
  assign pslverr = psel & penable & ~addrHit;

  // Command bits act as one-cycle strobes
  wire        cmdWrite   = apbWrite & hitCmd;
  wire        sleepReq   = sleepRequest | (cmdWrite & pwdata[1]);
  wire        countClear = watchdogClear | (cmdWrite & pwdata[0]);

  wire [11:0] cfgReadback = cfgImage_reg |
                            (variant_reg ? `CFG_UNIMP_14PIN : `CFG_UNIMP_8PIN);

  wire [2:0]  imageMode = decodeMode(variant_reg, cfgImage_reg);

  wire        pinResetAct = ~sharedPinIo & ~resetPinInput_n;

  // ****************************************
  // Watchdog
  // ****************************************
  // counts own oscillator ticks
  wire watchdogRun     = watchdogEnabled & (state_reg[2] | state_reg[3]);
  wire watchdogExpired = watchdogRun & watchdogOscTick &
                         (watchdogCount_reg == `WATCHDOG_LAST_TICK);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdogCount_reg <= 8'h00;
    end else if (!watchdogRun || countClear || watchdogExpired) begin
      watchdogCount_reg <= 8'h00;
    end else if (watchdogOscTick) begin
      watchdogCount_reg <= watchdogCount_reg + 8'h01;
    end
  end

  // ****************************************
  // Reset and sleep sequencing
  // ****************************************
  always @* begin
    state_next      = state_reg;
    delayCount_next = delayCount_reg;
    case (state_reg)
      ST_HOLD: begin
        if (!pinResetAct) begin
          if (isCrystal(imageMode)) begin
            state_next      = ST_DELAY;
            delayCount_next = LONG_DELAY_CYCLES;
          end else if (powerUp_reg) begin
            state_next      = ST_DELAY;
            delayCount_next = SHORT_DELAY_CYCLES;
          end else begin
            state_next = ST_RUN;
          end
        end
      end
      ST_DELAY: begin
        if (pinResetAct) begin
          state_next = ST_HOLD;
        end else if (delayCount_reg <= 21'h000001) begin
          state_next      = ST_RUN;
          delayCount_next = 21'h000000;
        end else begin
          delayCount_next = delayCount_reg - 21'h000001;
        end
      end
      ST_RUN: begin
        if (pinResetAct || watchdogExpired) begin
          state_next = ST_HOLD;
        end else if (sleepReq) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (pinResetAct) begin
          state_next = ST_HOLD;
        end else if (pinChange || watchdogExpired) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_HOLD;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= ST_HOLD;
      delayCount_reg <= 21'h000000;
      powerUp_reg    <= 1'b1;
      watchdogReset_reg <= 1'b0;
      deviceReset    <= 1'b1;
      delayActive    <= 1'b0;
      sleeping       <= 1'b0;
    end else begin
      state_reg      <= state_next;
      delayCount_reg <= delayCount_next;
      deviceReset    <= state_next[0] | state_next[1];
      delayActive    <= state_next[1];
      sleeping       <= state_next[3];
      if (state_reg[1] && state_next[2]) begin
        powerUp_reg <= 1'b0;
      end
      if (state_reg[2] && watchdogExpired && !pinResetAct) begin
        watchdogReset_reg <= 1'b1;
      end else if (state_reg[2] && pinResetAct) begin
        watchdogReset_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Configuration capture
  // ****************************************
  // sampled on leaving reset hold
  wire captureCfg = state_reg[0] & ~pinResetAct;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      activeVariant_reg <= `CTRL_RESET;
      oscMode           <= `MODE_XTAL_LOW;
      internalOscFreq8M <= 1'b1;
      clockOutputEnable <= 1'b0;
      secondaryPinIo    <= 1'b0;
      sharedPinIo       <= 1'b0;
      codeProtectOn     <= 1'b0;
      watchdogEnabled   <= 1'b1;
    end else if (captureCfg) begin
      activeVariant_reg <= variant_reg;
      oscMode           <= imageMode;
      clockOutputEnable <= (imageMode == `MODE_INT_OSC_OUT) ||
                           (imageMode == `MODE_EXT_RC_OUT);
      secondaryPinIo    <= variant_reg &&
                           ((imageMode == `MODE_EXT_CLOCK) || (imageMode == `MODE_INT_OSC) ||
                            (imageMode == `MODE_EXT_RC));
      internalOscFreq8M <= fieldBit(variant_reg, cfgImage_reg, `FREQ_BIT_8PIN);
      sharedPinIo       <= ~fieldBit(variant_reg, cfgImage_reg, `RSTPIN_BIT_8PIN);
      codeProtectOn     <= ~fieldBit(variant_reg, cfgImage_reg, `PROTECT_BIT_8PIN);
      watchdogEnabled   <= fieldBit(variant_reg, cfgImage_reg, `WATCHDOG_EN_BIT_8PIN);
    end
  end

  // ****************************************
  // APB registers
  // ****************************************
  // twelve-bit image
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgImage_reg <= `CFG_RESET;
      variant_reg  <= `CTRL_RESET;
    end else if (apbWrite) begin
      if (hitCfg) begin
        cfgImage_reg <= pwdata[11:0];
      end
      if (hitCtrl) begin
        variant_reg <= pwdata[0];
      end
    end
  end

  // Read data latched in setup phase
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (apbSetup && !pwrite) begin
      if (hitCfg) begin
        prdata <= {20'h00000, cfgReadback};
      end else if (hitCtrl) begin
        prdata <= {30'h00000000, activeVariant_reg, variant_reg};
      end else if (hitStatus) begin
        prdata <= {18'h00000, watchdogReset_reg, powerUp_reg, sleeping,
                   delayActive, deviceReset, secondaryPinIo,
                   clockOutputEnable, watchdogEnabled, codeProtectOn,
                   sharedPinIo, internalOscFreq8M, oscMode};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

endmodule

/* File: config_word_consts.vh */
`ifndef CONFIG_WORD_CONSTS_VH
`define CONFIG_WORD_CONSTS_VH

// ****************************************
// Timing
// ****************************************
// 18 ms and 1.125 ms at a 10 ns clock
`define DELAY_LONG_CYCLES  21'h1b7740
`define DELAY_SHORT_CYCLES 21'h01b774
`define WATCHDOG_LAST_TICK 8'hff

// ****************************************
// Register offsets
// ****************************************
`define ADDR_CFG    12'h000
`define ADDR_CTRL   12'h004
`define ADDR_STATUS 12'h008
`define ADDR_CMD    12'h00c

// ****************************************
// Configuration word layout
// ****************************************
`define CFG_RESET       12'hfff
`define CFG_UNIMP_8PIN  12'hfc0
`define CFG_UNIMP_14PIN 12'hf80
`define FREQ_BIT_8PIN        4'h5
`define RSTPIN_BIT_8PIN      4'h4
`define PROTECT_BIT_8PIN     4'h3
`define WATCHDOG_EN_BIT_8PIN 4'h2
`define CTRL_RESET      1'b0

// ****************************************
// Normalised oscillator modes
// ****************************************
`define MODE_XTAL_LOW    3'h0
`define MODE_XTAL_STD    3'h1
`define MODE_XTAL_FAST   3'h2
`define MODE_EXT_CLOCK   3'h3
`define MODE_INT_OSC     3'h4
`define MODE_INT_OSC_OUT 3'h5
`define MODE_EXT_RC      3'h6
`define MODE_EXT_RC_OUT  3'h7

`endif

/* File: test_config_word_clock_reset_select.sv */
module test_config_word_clock_reset_select;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LONG = 40;
  localparam int SHORT = 10;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0, w;
  logic [31:0] pwdata = 0;
  logic        resetPinInput_n = 1, tickEn = 0, kick = 0, v;
  logic        sleepPulse = 0, clearPulse = 0;
  wire  [31:0] prdata;
  wire  [2:0]  oscMode;
  wire         pready, pslverr, pinChange, watchdogOscTick, internalOscFreq8M, sleeping;
  wire         clockOutputEnable, secondaryPinIo, sharedPinIo, codeProtectOn;
  wire         watchdogEnabled, deviceReset, delayActive;
  int          errors = 0, samplesChecked = 0, cyc = 0, n;
  logic [11:0] expQ[$];
  always #5 clk = ~clk;
  config_word_clock_reset_select #(.LONG_DELAY_CYCLES(21'(LONG)),
    .SHORT_DELAY_CYCLES(21'(SHORT))) config_word_clock_reset_select_inst (.clk, .rst_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .resetPinInput_n, .pinChange, .watchdogOscTick, .sleepRequest(sleepPulse),
    .watchdogClear(clearPulse), .oscMode, .internalOscFreq8M, .clockOutputEnable,
    .secondaryPinIo, .sharedPinIo, .codeProtectOn, .watchdogEnabled, .deviceReset,
    .delayActive, .sleeping);
  clock_source_model clock_source_model_inst (.clk, .rst_n, .tickEn, .wakeKick(kick),
    .watchdogOscTick, .pinChange);
  task automatic finishTest;
    $display("checked %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string s);
    samplesChecked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [11:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic waitRun(output int d);
    d = 0;
    @(posedge clk);
    while (deviceReset !== 1'b0) begin
      d += delayActive;
      @(posedge clk);
    end
  endtask
  task automatic apply(input logic v14, input logic [11:0] c, input logic cry);
    apb(1'b1, 12'h004, {31'h0, v14});
    apb(1'b1, 12'h000, {20'h0, c});
    resetPinInput_n <= 1'b0;
    repeat (2) @(posedge clk);
    resetPinInput_n <= 1'b1;
    waitRun(n);
    check(12'(cry ? n >= LONG - 1 && n <= LONG + 1 : n == 0), 12'h1, "delay");
  endtask
  function automatic logic [11:0] stat(input logic v14, input logic [11:0] c);
    logic [3:0] f;
    logic [2:0] m;
    f = v14 ? c[6:3] : c[5:2];
    m = v14 ? c[2:0] : {c[1], c[1] & c[0], !c[1] & c[0]};
    return {3'h0, v14 && m inside {3, 4, 6}, v14 && m[2] && m[0], f[0], !f[1], !f[2], f[3], m};
  endfunction
  always @(posedge clk) begin
    if (psel && penable && pready)
      check(12'(pslverr), 12'(paddr > 12'h00c), "slave error");
    if (psel && penable && !pwrite && pready)
      check(prdata[11:0], expQ.pop_front(), "read data");
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finishTest();
    end
  end
  initial begin
    void'($urandom(32'h7077));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    waitRun(n);
    check(12'(n >= SHORT - 1 && n <= SHORT + 1), 12'h1, "power-up delay");
    rd(12'h000, 12'hfff);
    rd(12'h010, 12'h000);
    $display("test power-up done");
    for (int i = 0; i < 12; i++) begin
      v = i > 3;
      w = 12'($urandom);
      if (v) w = {w[11:6], 1'b1, w[4:3], 3'(i - 4)};
      else w = {w[11:5], 1'b1, w[3:2], 2'(i)};
      apply(v, w, v ? i < 7 : i < 2);
      rd(12'h000, w | (v ? 12'hf80 : 12'hfc0));
      rd(12'h008, stat(v, w));
      rd(12'h004, {10'h0, v, v});
    end
    $display("test modes done");
    apply(1'b0, 12'h015, 1'b1);
    apb(1'b1, 12'h00c, 32'h2);
    rd(12'h008, stat(1'b0, 12'h015) | 12'h800);
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    repeat (3) @(posedge clk);
    rd(12'h008, stat(1'b0, 12'h015));
    sleepPulse <= 1'b1;
    clearPulse <= 1'b1;
    @(posedge clk);
    sleepPulse <= 1'b0;
    clearPulse <= 1'b0;
    tickEn <= 1'b1;
    repeat (2) @(posedge clk);
    while (sleeping !== 1'b0) @(posedge clk);
    tickEn <= 1'b0;
    check(12'(deviceReset), 12'h0, "watchdog wake");
    $display("test sleep done");
    @(posedge clk);
    tickEn <= 1'b1;
    while (deviceReset !== 1'b1) @(posedge clk);
    tickEn <= 1'b0;
    waitRun(n);
    check(12'(n >= LONG - 1 && n <= LONG + 1), 12'h1, "watchdog reset delay");
    $display("test watchdog reset done");
    apply(1'b0, 12'h002, 1'b0);
    tickEn <= 1'b1;
    resetPinInput_n <= 1'b0;
    repeat (1100) @(posedge clk);
    check(12'(deviceReset), 12'h0, "held run");
    apb(1'b1, 12'h000, 32'hfff);
    rd(12'h008, stat(1'b0, 12'h002));
    $display("test pin and watchdog done");
    finishTest();
  end
endmodule
